// *** rtl/ccppw_top.sv ***
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module ccppw_top
(
    input  wire logic        pclk,              // Oscillator clock
    input  wire logic        presetn,           // Async reset, active low
    input  wire logic        ce,                // Clock enable
    input  wire logic        psel,              // APB select
    input  wire logic        penable,           // APB enable
    input  wire logic        pwrite,            // APB write
    input  wire logic [7:0]  paddr,             // APB byte address
    input  wire logic [31:0] pwdata,            // APB write data
    output logic      [31:0] prdata,            // APB read data
    output logic             pready,            // APB ready
    output logic             pslverr,           // APB error
    output logic             primary_output,    // PWM waveform
    output logic             complement_output, // Complement waveform
    output logic             primary_oe,        // Primary pin drive enable
    output logic             complement_oe,     // Complement pin drive enable
    output logic             irq                // Level interrupt
);
    logic [7:0] unit_ctrl;
    logic [7:0] duty_low;
    logic [1:0] tsel;
    logic [6:0] dead_band_count;
    logic [2:0] tctrl [0:2];
    logic [7:0] period [0:2];
    logic [2:0] status;
    logic [2:0] mask;
    logic [7:0] pinmap;
    logic [1:0] pindir;
    logic [7:0] next_unit_ctrl;
    logic [7:0] next_duty_low;
    logic [1:0] next_tsel;
    logic [6:0] next_dead;
    logic [2:0] next_tctrl [0:2];
    logic [7:0] next_period [0:2];
    logic [2:0] next_status;
    logic [2:0] next_mask;
    logic [7:0] next_pinmap;
    logic [1:0] next_pindir;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic        next_irq;
    logic        next_pa;
    logic        next_pb;
    logic        wr_en;
    logic        rd_done;
    logic        hit;
    logic        buf_wr;
    logic [1:0]  idx;
    logic [31:0] rd_val;
    logic [1:0]  osc_phase;
    logic [7:0]  t_count [0:2];
    logic [1:0]  t_low [0:2];
    logic [2:0]  t_match;
    logic [7:0]  sel_count;
    logic [1:0]  sel_low;
    logic        sel_match;
    logic        pwm_en;
    logic        half;
    logic [9:0]  duty_new;
    logic [9:0]  time_base;
    logic [7:0]  duty_buf;
    logic [1:0]  duty_latch;
    logic        raw;
    logic [6:0]  db_cnt;
    logic [7:0]  next_buf;
    logic [1:0]  next_latch;
    logic        next_raw;
    logic [6:0]  next_db;

    // Oscillator sub-count, one instruction cycle per wrap
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            osc_phase <= 2'h0;
        else if (ce)
            osc_phase <= osc_phase + 2'h1;
    end

    genvar g;
    generate
        for (g = 0; g < ccppw_pkg::NUM_TIMERS; g++)
        begin : g_tmr
            ccppw_timer u_tmr
            (
                .pclk      (pclk),
                .presetn   (presetn),
                .ce        (ce),
                .run       (tctrl[g][ccppw_pkg::TCTRL_RUN_BIT]),
                .prescale  (tctrl[g][1:0]),
                .period    (period[g]),
                .osc_phase (osc_phase),
                .count     (t_count[g]),
                .low_bits  (t_low[g]),
                .match     (t_match[g])
            );
        end
    endgenerate

    // Bus decode and read mux
    always_comb
    begin
        wr_en   = psel && penable && pready && pwrite;
        rd_done = psel && penable && pready && !pwrite;
        idx     = paddr[3:2];
        hit     = (paddr[1:0] == 2'h0);
        rd_val  = 32'h0000_0000;
        case (paddr[7:4])
            ccppw_pkg::REGION_TCTRL:  rd_val = {29'h0, tctrl[idx]};
            ccppw_pkg::REGION_PERIOD: rd_val = {24'h0, period[idx]};
            ccppw_pkg::REGION_COUNT:  rd_val = {24'h0, t_count[idx]};
            default:
            begin
                case (paddr)
                    ccppw_pkg::OFS_UNIT_CTRL: rd_val = {24'h0, unit_ctrl};
                    ccppw_pkg::OFS_DUTY_LOW:  rd_val = {24'h0, duty_low};
                    ccppw_pkg::OFS_DUTY_BUF:  rd_val = {24'h0, duty_buf};
                    ccppw_pkg::OFS_TSEL:      rd_val = {30'h0, tsel};
                    ccppw_pkg::OFS_DEAD:      rd_val = {25'h0, dead_band_count};
                    ccppw_pkg::OFS_STATUS:    rd_val = {29'h0, status};
                    ccppw_pkg::OFS_MASK:      rd_val = {29'h0, mask};
                    ccppw_pkg::OFS_PINMAP:    rd_val = {24'h0, pinmap};
                    ccppw_pkg::OFS_PINDIR:    rd_val = {30'h0, pindir};
                    default:                  hit = 1'b0;
                endcase
            end
        endcase
        if ((paddr[7:4] == ccppw_pkg::REGION_TCTRL || paddr[7:4] == ccppw_pkg::REGION_PERIOD
             || paddr[7:4] == ccppw_pkg::REGION_COUNT) && idx == 2'h3)
            hit = 1'b0;
        next_pready  = psel && !penable;
        next_pslverr = psel && !penable && !hit;
        next_prdata  = (psel && !penable && hit) ? rd_val : 32'h0000_0000;
        buf_wr       = wr_en && hit && (paddr == ccppw_pkg::OFS_DUTY_BUF);
    end

    // Register file next values
    always_comb
    begin
        next_unit_ctrl = unit_ctrl;
        next_duty_low  = duty_low;
        next_tsel      = tsel;
        next_dead      = dead_band_count;
        next_tctrl     = tctrl;
        next_period    = period;
        next_mask      = mask;
        next_pinmap    = pinmap;
        next_pindir    = pindir;
        next_status    = status;
        if (rd_done && paddr == ccppw_pkg::OFS_STATUS)
            next_status = 3'h0;
        next_status = next_status | t_match;
        if (wr_en && hit)
        begin
            case (paddr[7:4])
                ccppw_pkg::REGION_TCTRL:  next_tctrl[idx]  = pwdata[2:0];
                ccppw_pkg::REGION_PERIOD: next_period[idx] = pwdata[7:0];
                default:
                begin
                    case (paddr)
                        ccppw_pkg::OFS_UNIT_CTRL:
                            next_unit_ctrl = pwdata[7:0] & ccppw_pkg::CTRL_MASK;
                        ccppw_pkg::OFS_DUTY_LOW: next_duty_low = pwdata[7:0]; // RULE6
                        ccppw_pkg::OFS_TSEL:     next_tsel     = pwdata[1:0];
                        ccppw_pkg::OFS_DEAD:     next_dead     = pwdata[6:0];
                        ccppw_pkg::OFS_MASK:     next_mask     = pwdata[2:0];
                        ccppw_pkg::OFS_PINMAP:   next_pinmap   = pwdata[7:0];
                        ccppw_pkg::OFS_PINDIR:   next_pindir   = pwdata[1:0];
                        default:                 next_pinmap   = pinmap;
                    endcase
                end
            endcase
        end
        next_irq = |(next_status & next_mask);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            unit_ctrl       <= ccppw_pkg::RST_UNIT_CTRL;
            duty_low        <= 8'h00;
            tsel            <= 2'h0;
            dead_band_count <= 7'h00;
            for (int k = 0; k < ccppw_pkg::NUM_TIMERS; k++)
            begin
                tctrl[k]  <= 3'h0;
                period[k] <= ccppw_pkg::RST_PERIOD;
            end
            status  <= 3'h0;
            mask    <= 3'h0;
            pinmap  <= 8'h00;
            pindir  <= ccppw_pkg::RST_PINDIR;
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            irq     <= 1'b0;
        end
        else if (ce)
        begin
            unit_ctrl       <= next_unit_ctrl;
            duty_low        <= next_duty_low;
            tsel            <= next_tsel;
            dead_band_count <= next_dead;
            tctrl           <= next_tctrl;
            period          <= next_period;
            status          <= next_status;
            mask            <= next_mask;
            pinmap          <= next_pinmap;
            pindir          <= next_pindir;
            prdata          <= next_prdata;
            pready          <= next_pready;
            pslverr         <= next_pslverr;
            irq             <= next_irq;
        end
    end

    // PWM engine
    always_comb
    begin
        pwm_en = unit_ctrl[ccppw_pkg::CTRL_EN_BIT];
        half   = unit_ctrl[ccppw_pkg::CTRL_HB_BIT];
        case (tsel) // RULE1
            2'h0:
            begin
                sel_count = t_count[0];
                sel_low   = t_low[0];
                sel_match = t_match[0];
            end
            2'h1:
            begin
                sel_count = t_count[1];
                sel_low   = t_low[1];
                sel_match = t_match[1];
            end
            2'h2:
            begin
                sel_count = t_count[2];
                sel_low   = t_low[2];
                sel_match = t_match[2];
            end
            default:
            begin
                sel_count = 8'h00;
                sel_low   = 2'h0;
                sel_match = 1'b0;
            end
        endcase
        duty_new   = {duty_low, unit_ctrl[ccppw_pkg::CTRL_LSB_LO +: 2]}; // RULE5
        time_base  = {sel_count, sel_low}; // RULE10 RULE2
        next_buf   = duty_buf;
        next_latch = duty_latch;
        next_raw   = raw;
        if (!pwm_en)
        begin
            next_raw = 1'b0;
            if (buf_wr)
                next_buf = pwdata[7:0]; // RULE7
        end
        else if (sel_match)
        begin
            next_buf   = duty_new[9:2]; // RULE9 RULE6
            next_latch = duty_new[1:0];
            next_raw   = (duty_new != 10'h000); // RULE3
        end
        else if ({duty_buf, duty_latch} == time_base)
        begin
            next_raw = 1'b0; // RULE11 RULE8
        end
        next_db = db_cnt;
        if (next_raw != raw)
            next_db = dead_band_count; // RULE13
        else if (db_cnt != 7'h00 && osc_phase == ccppw_pkg::INSTR_LAST)
            next_db = db_cnt - 7'h01;
        if (half)
        begin
            // Edge that arrives before the delay runs out keeps output idle
            next_pa = pwm_en && raw && (db_cnt == 7'h00); // RULE12 RULE14
            next_pb = pwm_en && !raw && (db_cnt == 7'h00); // RULE12 RULE14
        end
        else
        begin
            next_pa = pwm_en && raw;
            next_pb = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            duty_buf          <= 8'h00;
            duty_latch        <= 2'h0;
            raw               <= 1'b0;
            db_cnt            <= 7'h00;
            primary_output    <= 1'b0;
            complement_output <= 1'b0;
            primary_oe        <= 1'b0;
            complement_oe     <= 1'b0;
        end
        else if (ce)
        begin
            duty_buf          <= next_buf;
            duty_latch        <= next_latch;
            raw               <= next_raw;
            db_cnt            <= next_db;
            primary_output    <= next_pa;
            complement_output <= next_pb;
            primary_oe        <= !pindir[0]; // RULE15
            complement_oe     <= !pindir[1]; // RULE15
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_duty_latch_match: assert property (ce && pwm_en && sel_match // RULE6
        |=> {duty_buf, duty_latch} == $past(duty_new))
        else $error("duty not latched at period match");
    a_zero_duty_idle: assert property (ce && pwm_en && sel_match && duty_new == 10'h000 // RULE3
        |=> !raw ##1 !primary_output)
        else $error("zero duty still set the output");
    a_compare_clears: assert property (ce && raw && !sel_match // RULE11
        && {duty_buf, duty_latch} == time_base |=> !raw)
        else $error("output not cleared on duty compare");
    a_buf_read_only: assert property (ce && pwm_en && buf_wr && !sel_match // RULE7
        |=> $stable(duty_buf))
        else $error("duty buffer written while running");
    a_pair_exclusive: assert property (!(primary_output && complement_output)) // RULE12
        else $error("both outputs active");
    a_dead_band_hold: assert property (ce && half && db_cnt != 7'h00 // RULE13
        |=> !primary_output && !complement_output)
        else $error("output active inside dead band");
    a_irq_level: assert property (irq == |(status & mask))
        else $error("interrupt does not follow masked status");
    a_status_sticky: assert property (ce && |t_match // RULE16
        |=> (status & $past(t_match)) == $past(t_match))
        else $error("timer flag not captured");
endmodule
`default_nettype wire

// *** include/ccppw_pkg.sv ***
// Notes on behaviour
// RULE1: PWM period comes from one of three 8-bit timers picked by a select field.
// RULE2: Period is (period register + 1) times four oscillator periods times prescale.
// RULE3: After count equals period: clear timer, set output unless duty zero, latch duty.
// RULE4: No postscaler takes part in the PWM period.
// RULE5: Duty is 10 bits: eight high bits in duty low register, two in control 5:4.
// RULE6: Duty fields writable anytime; new value reaches buffer only at period match.
// RULE7: Duty buffer high register is read-only while PWM runs.
// RULE8: High time equals duty value times oscillator period times prescale.
// RULE9: Duty is double-buffered in buffer high register plus a hidden two-bit latch.
// RULE10: Time base is timer count plus sub-count bits at 1:1, else prescaler bits.
// RULE11: Output goes low when the time base equals the buffered duty.
// RULE12: Half-bridge drives the waveform on primary and its complement on second output.
// RULE13: Seven-bit dead-band count delays each output going active, in instruction cycles.
// RULE14: Dead-band longer than the active time keeps that output inactive all cycle.
// RULE15: Software must clear both pin direction bits to use the pins as outputs.
// RULE16: Software starts the timer, waits for its flag, then enables the driver; the bench sets enable first and never waits for the flag.
// RULE17: Timer advances once per instruction cycle, four oscillator cycles, over prescale.
`default_nettype none
package ccppw_pkg;
    localparam int          CLK_PERIOD_NS  = 5;
    localparam int          NUM_TIMERS     = 3;
    localparam logic [1:0]  INSTR_LAST     = 2'h3;
    localparam logic [1:0]  PS_DIV1        = 2'h0;
    localparam logic [1:0]  PS_DIV4        = 2'h1;
    localparam logic [7:0]  OFS_UNIT_CTRL  = 8'h00;
    localparam logic [7:0]  OFS_DUTY_LOW   = 8'h04;
    localparam logic [7:0]  OFS_DUTY_BUF   = 8'h08;
    localparam logic [7:0]  OFS_TSEL       = 8'h0C;
    localparam logic [7:0]  OFS_DEAD       = 8'h10;
    localparam logic [7:0]  OFS_STATUS     = 8'h14;
    localparam logic [7:0]  OFS_MASK       = 8'h18;
    localparam logic [7:0]  OFS_PINMAP     = 8'h1C;
    localparam logic [7:0]  OFS_PINDIR     = 8'h24;
    localparam logic [3:0]  REGION_TCTRL   = 4'h4;
    localparam logic [3:0]  REGION_PERIOD  = 4'h5;
    localparam logic [3:0]  REGION_COUNT   = 4'h6;
    localparam int          CTRL_EN_BIT    = 0;
    localparam int          CTRL_HB_BIT    = 1;
    localparam int          CTRL_LSB_LO    = 4;
    localparam logic [7:0]  CTRL_MASK      = 8'h33;
    localparam int          TCTRL_RUN_BIT  = 2;
    localparam logic [7:0]  RST_UNIT_CTRL  = 8'h00;
    localparam logic [7:0]  RST_PERIOD     = 8'hFF;
    localparam logic [1:0]  RST_PINDIR     = 2'h3;
    localparam logic [1:0]  TSEL_NONE      = 2'h3;
endpackage
`default_nettype wire

// *** rtl/ccppw_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
module ccppw_timer
(
    input  wire logic       pclk,       // Oscillator clock
    input  wire logic       presetn,    // Async reset, active low
    input  wire logic       ce,         // Clock enable
    input  wire logic       run,        // Timer run bit
    input  wire logic [1:0] prescale,   // Prescale code
    input  wire logic [7:0] period,     // Period register
    input  wire logic [1:0] osc_phase,  // Oscillator sub-count
    output logic      [7:0] count,      // Timer count
    output logic      [1:0] low_bits,   // Lower time base bits
    output logic            match       // Pulse on period wrap
);
    logic [3:0] presc;
    logic [3:0] next_presc;
    logic [7:0] next_count;
    logic       next_match;
    logic       tick;
    logic       wrap;

    always_comb
    begin
        tick = run && (osc_phase == ccppw_pkg::INSTR_LAST); // RULE17
        case (prescale)
            ccppw_pkg::PS_DIV1: wrap = 1'b1;
            ccppw_pkg::PS_DIV4: wrap = (presc[1:0] == 2'h3);
            default:            wrap = (presc == 4'hF);
        endcase
        case (prescale) // RULE10
            ccppw_pkg::PS_DIV1: low_bits = osc_phase;
            ccppw_pkg::PS_DIV4: low_bits = presc[1:0];
            default:            low_bits = presc[3:2];
        endcase
        next_presc = presc;
        next_count = count;
        next_match = 1'b0;
        if (tick)
        begin
            next_presc = wrap ? 4'h0 : presc + 4'h1;
            if (wrap && (count == period))
            begin
                // Wrap reported undivided, no postscale
                next_count = 8'h00; // RULE3 RULE4
                next_match = 1'b1;
            end
            else if (wrap)
            begin
                next_count = count + 8'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            presc <= 4'h0;
            count <= 8'h00;
            match <= 1'b0;
        end
        else if (ce)
        begin
            presc <= next_presc;
            count <= next_count;
            match <= next_match;
        end
    end

    a_wrap_clears_count: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
        ce && tick && wrap && count == period |=> match && count == 8'h00)
        else $error("timer did not clear on period match");
    a_count_step_one: assert property (@(posedge pclk) disable iff (!presetn) // RULE17
        ce && tick && wrap && count != period |=> count == $past(count) + 8'h01)
        else $error("timer did not advance by one");
endmodule
`default_nettype wire

// *** bench/ccppw_load_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module ccppw_load_model
(
    input  wire logic pclk,              // Oscillator clock
    input  wire logic presetn,           // Async reset, active low
    input  wire logic high_side,         // Primary switch gate
    input  wire logic low_side,          // Complement switch gate
    input  wire logic high_side_oe,      // Primary pin driven
    input  wire logic low_side_oe,       // Complement pin driven
    output logic      shoot_through      // Both switches seen on together
);
    // Undriven pins float to the pull-down level of the gate drivers
    logic gate_hi;
    logic gate_lo;
    assign gate_hi = high_side_oe ? high_side : 1'b0;
    assign gate_lo = low_side_oe ? low_side : 1'b0;
    // Sticky so a single bad cycle is never lost
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            shoot_through <= 1'b0;
        else if (gate_hi && gate_lo)
            shoot_through <= 1'b1;
    end
endmodule
`default_nettype wire

// *** bench/test_ccp_pwm_half_bridge.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_ccp_pwm_half_bridge;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        ce = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        primary_output;
    logic        complement_output;
    logic        primary_oe;
    logic        complement_oe;
    logic        irq;
    logic        shoot_through;
    int          n_mismatch = 0;
    int          n_tests = 0;
    always #2.5 pclk = ~pclk;
    ccppw_top i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .primary_output(primary_output), .complement_output(complement_output),
        .primary_oe(primary_oe), .complement_oe(complement_oe), .irq(irq));
    ccppw_load_model i_load (.pclk(pclk), .presetn(presetn), .high_side(primary_output),
        .low_side(complement_output), .high_side_oe(primary_oe),
        .low_side_oe(complement_oe), .shoot_through(shoot_through));
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp,
                          input logic exp_err);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        chk(what, q, exp);
        chk({what, " err"}, {31'h0, e}, {31'h0, exp_err});
    endtask
    function automatic logic pick(input logic which);
        return which ? complement_output : primary_output;
    endfunction
    task automatic measure(input logic which, output int hi, output int per);
        int n;
        n = 0;
        hi = 0;
        while (pick(which) !== 1'b0 && n < 3000) begin @(posedge pclk); n++; end
        while (pick(which) !== 1'b1 && n < 3000) begin @(posedge pclk); n++; end
        while (pick(which) === 1'b1 && n < 3000) begin @(posedge pclk); n++; hi++; end
        per = hi;
        while (pick(which) !== 1'b1 && n < 3000) begin @(posedge pclk); n++; per++; end
        chk("measure limit", {31'h0, n >= 3000}, 32'h0000_0000);
    endtask
    task automatic pwm_cfg(input int k, input logic [7:0] per, input logic [1:0] ps,
                           input logic [9:0] d, input logic hb, input logic [6:0] db);
        logic [7:0] t;
        t = 8'(4 * k);
        wr(8'h00, 32'h0000_0000);
        wr(ccppw_pkg::OFS_TSEL, 32'(k));
        wr(8'h40 + t, 32'h0000_0000);
        wr(8'h50 + t, {24'h0, per});
        wr(ccppw_pkg::OFS_DUTY_LOW, {24'h0, d[9:2]});
        wr(ccppw_pkg::OFS_DEAD, {25'h0, db});
        wr(8'h00, {26'h0, d[1:0], 2'b00, hb, 1'b1});
        wr(8'h40 + t, {29'h0, 1'b1, ps});
    endtask
    task automatic t_regs();
        rd_chk("ctrl reset", ccppw_pkg::OFS_UNIT_CTRL, 32'h0000_0000, 1'b0);
        rd_chk("pindir reset", ccppw_pkg::OFS_PINDIR, 32'h0000_0003, 1'b0);
        rd_chk("period reset", 8'h50, 32'h0000_00FF, 1'b0);
        rd_chk("pinmap reset", ccppw_pkg::OFS_PINMAP, 32'h0000_0000, 1'b0);
        rd_chk("unmapped", 8'h30, 32'h0000_0000, 1'b1);
        rd_chk("misaligned", 8'h02, 32'h0000_0000, 1'b1);
        wr(ccppw_pkg::OFS_PINMAP, 32'h0000_00A5);
        rd_chk("pinmap rw", ccppw_pkg::OFS_PINMAP, 32'h0000_00A5, 1'b0);
        chk("oe off", {30'h0, primary_oe, complement_oe}, 32'h0000_0000);
        wr(ccppw_pkg::OFS_PINDIR, 32'h0000_0000);
        repeat (2) @(posedge pclk);
        chk("oe on", {30'h0, primary_oe, complement_oe}, 32'h0000_0003);
        $display("test regs done");
    endtask
    task automatic t_period();
        int hi;
        int per;
        pwm_cfg(0, 8'h03, ccppw_pkg::PS_DIV1, 10'd6, 1'b0, 7'd0);
        measure(1'b0, hi, per);
        chk("hi 1:1", hi, 6);
        chk("per 1:1", per, 16);
        pwm_cfg(1, 8'h03, ccppw_pkg::PS_DIV4, 10'd6, 1'b0, 7'd0);
        measure(1'b0, hi, per);
        chk("hi 1:4", hi, 24);
        chk("per 1:4", per, 64);
        pwm_cfg(2, 8'h03, 2'h2, 10'd6, 1'b0, 7'd0);
        measure(1'b0, hi, per);
        chk("hi 1:16", hi, 96);
        chk("per 1:16", per, 256);
        wr(ccppw_pkg::OFS_DUTY_LOW, 32'h0000_0000);
        wr(8'h00, 32'h0000_0001);
        repeat (300) @(posedge pclk);
        hi = 0;
        repeat (140) begin @(posedge pclk); hi += int'(primary_output === 1'b1); end
        chk("duty zero", hi, 0);
        wr(ccppw_pkg::OFS_TSEL, 32'(ccppw_pkg::TSEL_NONE));
        // Stop timers 1 and 2; their flags stay sticky
        wr(8'h44, 32'h0000_0000);
        wr(8'h48, 32'h0000_0000);
        $display("test period done");
    endtask
    task automatic t_buffer();
        pwm_cfg(0, 8'hFF, ccppw_pkg::PS_DIV1, 10'd4, 1'b0, 7'd0);
        repeat (1100) @(posedge pclk);
        wr(ccppw_pkg::OFS_DUTY_LOW, 32'h0000_0055);
        rd_chk("buf old", ccppw_pkg::OFS_DUTY_BUF, 32'h0000_0001, 1'b0);
        repeat (1100) @(posedge pclk);
        rd_chk("buf new", ccppw_pkg::OFS_DUTY_BUF, 32'h0000_0055, 1'b0);
        wr(ccppw_pkg::OFS_DUTY_BUF, 32'h0000_0012);
        rd_chk("buf ro", ccppw_pkg::OFS_DUTY_BUF, 32'h0000_0055, 1'b0);
        $display("test buffer done");
    endtask
    task automatic t_irq();
        wr(ccppw_pkg::OFS_MASK, 32'h0000_0001);
        repeat (1100) @(posedge pclk);
        chk("irq set", {31'h0, irq}, 32'h0000_0001);
        rd_chk("status", ccppw_pkg::OFS_STATUS, 32'h0000_0007, 1'b0);
        rd_chk("status clr", ccppw_pkg::OFS_STATUS, 32'h0000_0000, 1'b0);
        chk("irq clr", {31'h0, irq}, 32'h0000_0000);
        wr(ccppw_pkg::OFS_MASK, 32'h0000_0000);
        repeat (1100) @(posedge pclk);
        chk("irq masked", {31'h0, irq}, 32'h0000_0000);
        rd_chk("status masked", ccppw_pkg::OFS_STATUS, 32'h0000_0001, 1'b0);
        $display("test irq done");
    endtask
    task automatic t_half();
        int hi;
        int per;
        logic [31:0] qa;
        logic [31:0] qb;
        logic        e;
        pwm_cfg(0, 8'hFF, ccppw_pkg::PS_DIV1, 10'd400, 1'b1, 7'd2);
        repeat (1100) @(posedge pclk);
        measure(1'b0, hi, per);
        chk("pri db", {31'h0, hi >= 391 && hi <= 394}, 32'h0000_0001);
        measure(1'b1, hi, per);
        chk("cmp db", {31'h0, hi >= 615 && hi <= 618}, 32'h0000_0001);
        chk("cmp per", per, 1024);
        wr(ccppw_pkg::OFS_DEAD, 32'h0000_007F);
        repeat (1100) @(posedge pclk);
        hi = 0;
        repeat (1100) begin @(posedge pclk); hi += int'(primary_output === 1'b1); end
        chk("db over duty", hi, 0);
        chk("no overlap", {31'h0, shoot_through}, 32'h0000_0000);
        // Clock enable low must freeze the running timer
        apb(1'b0, 8'h60, 32'h0000_0000, qa, e);
        ce <= 1'b0;
        repeat (200) @(posedge pclk);
        ce <= 1'b1;
        apb(1'b0, 8'h60, 32'h0000_0000, qb, e);
        chk("ce freeze", {31'h0, 8'(qb[7:0] - qa[7:0]) <= 8'h01}, 32'h0000_0001);
        $display("test half done");
    endtask
    initial
    begin
        repeat (40000) @(posedge pclk);
        n_mismatch++;
        close_out();
    end
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_period();
        t_buffer();
        t_irq();
        t_half();
        close_out();
    end
endmodule
`default_nettype wire
